// file: dv/atseq_top_bench.sv
// Self-checking bench of the auto-trigger sequencer.
`timescale 1ns/1ps
module atseq_top_bench;
	typedef struct {logic typ; logic [3:0] sel; int ch;} atseq_exp_t;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic ce = 1'b1;
	logic two_channel_enable = 1'b0;
	logic [2:0] group_count_field = 3'h0;
	logic [1:0] trigger_select_field = 2'h3;
	logic [3:0] interval_field = 4'h0;
	logic [4:0] blanking_time_field = 5'h0;
	logic ch1_source_type = 1'b0;
	logic [3:0] ch1_source_select = 4'h0;
	logic ch2_source_type = 1'b0;
	logic [3:0] ch2_source_select = 4'h0;
	logic timer_ext_enable = 1'b1;
	logic [15:0] timer_preload_value = 16'hfff0;
	logic start_set = 1'b0;
	logic start_clear = 1'b0;
	logic irq_flag_clear = 1'b0;
	logic pwm_sync_input = 1'b0;
	logic comparator_output_signal = 1'b0;
	logic conv_done = 1'b0;
	logic [11:0] conv_data = 12'h000;
	logic auto_start_bit, converter_irq_flag, retrigger_overlap_flag;
	logic conversion_busy_flag, conv_start, channel_source_type, timer_run_bit;
	logic [3:0] channel_source_select;
	logic [15:0] channel_one_sum, channel_two_sum;
	int num_errors = 0;
	int n_compared = 0;
	int done_cnt = 0;
	time t_done = 0;
	logic [31:0] rng = 32'd58265;
	logic hold_done = 1'b0;
	logic discard = 1'b0;
	logic gap_chk = 1'b0;
	logic [15:0] exp_sum [1:2];
	atseq_exp_t exp_q [$];

	atseq_top #(.DATA_W(12)) u_atseq_top (.clk, .nrst, .ce,
		.two_channel_enable, .group_count_field, .trigger_select_field,
		.interval_field, .blanking_time_field, .ch1_source_type,
		.ch1_source_select, .ch2_source_type, .ch2_source_select,
		.timer_ext_enable, .timer_preload_value, .start_set, .start_clear,
		.irq_flag_clear, .pwm_sync_input, .comparator_output_signal,
		.conv_done, .conv_data, .auto_start_bit, .converter_irq_flag,
		.retrigger_overlap_flag, .conversion_busy_flag, .conv_start,
		.channel_source_type, .channel_source_select, .channel_one_sum,
		.channel_two_sum, .timer_run_bit);

	initial begin
		forever #50 clk = ~clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	task automatic report_and_stop;
		$display("compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic ok, input string msg);
		n_compared++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic pulse_start(input logic set);
		start_set = set;
		start_clear = !set;
		step(1);
		start_set = 1'b0;
		start_clear = 1'b0;
	endtask

	// Every wait is bounded so a stuck sequencer ends the run cleanly.
	task automatic wait_cnt(input int target);
		int i;
		for (i = 0; i < 3000 && done_cnt < target; i++) step(1);
		if (done_cnt < target) begin
			check(1'b0, "conversion never completed");
			report_and_stop();
		end
	endtask

	task automatic wait_busy;
		int i;
		for (i = 0; i < 300 && conversion_busy_flag !== 1'b1; i++) step(1);
		check(conversion_busy_flag === 1'b1, "busy never rose");
	endtask

	// Converter stand-in: pops the expected source of each start, answers
	// after a random delay and books the result into the expected sums.
	initial begin
		atseq_exp_t e;
		int d;
		forever begin
			// Outputs are read on the falling edge, where they have settled.
			@(negedge clk);
			if (conv_start === 1'b1) begin
				if (exp_q.size() == 0) begin
					check(1'b0, "unexpected conversion start");
				end else begin
					e = exp_q.pop_front();
					check(channel_source_type === e.typ &&
						channel_source_select === e.sel, "source");
					if ((gap_chk || e.ch == 2) && t_done != 0) begin
						check($time - t_done >= 1000 * interval_field,
							"interval too short");
					end
					rng = xs(rng);
					step(1 + int'(rng[1:0]));
					for (d = 0; d < 300 && hold_done; d++) step(1);
					if (hold_done) check(1'b0, "converter hold stuck");
					conv_data = rng[15:4];
					conv_done = 1'b1;
					if (!discard) exp_sum[e.ch] += {4'h0, rng[15:4]};
					step(1);
					conv_done = 1'b0;
					t_done = $time;
					done_cnt++;
				end
			end
		end
	end

	task automatic setup(input logic [1:0] trg, input logic two,
		input logic [2:0] cnt, input int n);
		int i;
		trigger_select_field = trg;
		two_channel_enable = two;
		group_count_field = cnt;
		gap_chk = (trg == 2'h3);
		rng = xs(rng);
		ch1_source_type = rng[4];
		ch1_source_select = rng[3:0];
		ch2_source_type = rng[9];
		ch2_source_select = rng[8:5];
		interval_field = {2'h0, rng[11:10]};
		blanking_time_field = rng[16:12];
		exp_sum[1] = 16'h0000;
		exp_sum[2] = 16'h0000;
		t_done = 0;
		done_cnt = 0;
		for (i = 0; i < n; i++) begin
			exp_q.push_back('{ch1_source_type, ch1_source_select, 1});
			if (two) exp_q.push_back('{ch2_source_type, ch2_source_select, 2});
		end
	endtask

	task automatic run_group(input logic [1:0] trg, input logic two,
		input logic [2:0] cnt);
		int n, i, k;
		n = 1 << (cnt - 1);
		k = two ? 2 : 1;
		setup(trg, two, cnt, n);
		pulse_start(1'b1);
		check(auto_start_bit === 1'b1, "not armed");
		check(retrigger_overlap_flag === 1'b0, "overlap kept");
		if (trg == 2'h2) begin
			step(3);
			check(timer_run_bit === 1'b1, "timer idle");
		end
		for (i = 0; i < n && trg <= 2'h1; i++) begin
			pwm_sync_input = (trg == 2'h0);
			comparator_output_signal = (trg == 2'h1);
			wait_cnt((i + 1) * k);
			pwm_sync_input = 1'b0;
			comparator_output_signal = 1'b0;
			step(4);
		end
		wait_cnt(n * k);
		step(3);
		check(channel_one_sum === exp_sum[1], "sum one");
		check(channel_two_sum === exp_sum[2], "sum two");
		check(auto_start_bit === 1'b0 && converter_irq_flag === 1'b1 &&
			timer_run_bit === 1'b0, "group end");
		irq_flag_clear = 1'b1;
		step(1);
		irq_flag_clear = 1'b0;
		check(converter_irq_flag === 1'b0, "flag not cleared");
	endtask

	initial begin
		int i;
		step(20);
		nrst = 1'b1;
		step(1);
		check({auto_start_bit, converter_irq_flag, retrigger_overlap_flag,
			conversion_busy_flag, conv_start, timer_run_bit} === 6'h00 &&
			channel_one_sum === 16'h0000, "reset values");
		pulse_start(1'b1);
		step(2);
		check(auto_start_bit === 1'b0, "armed with zero count");
		// A second edge while converting is flagged and dropped.
		setup(2'h0, 1'b0, 3'h1, 1);
		hold_done = 1'b1;
		pulse_start(1'b1);
		pwm_sync_input = 1'b1;
		wait_busy();
		pwm_sync_input = 1'b0;
		step(4);
		pwm_sync_input = 1'b1;
		step(5);
		check(retrigger_overlap_flag === 1'b1, "overlap not set");
		hold_done = 1'b0;
		wait_cnt(1);
		step(20);
		pwm_sync_input = 1'b0;
		check(auto_start_bit === 1'b0 && converter_irq_flag === 1'b1 &&
			channel_one_sum === exp_sum[1], "overlap group");
		irq_flag_clear = 1'b1;
		step(1);
		irq_flag_clear = 1'b0;
		// Every trigger source and every group size.
		run_group(2'h3, 1'b0, 3'h3);
		run_group(2'h3, 1'b1, 3'h4);
		run_group(2'h3, 1'b0, 3'h5);
		run_group(2'h0, 1'b0, 3'h2);
		run_group(2'h0, 1'b1, 3'h1);
		timer_preload_value = 16'hfff8;
		run_group(2'h1, 1'b1, 3'h2);
		timer_preload_value = 16'hfff0;
		run_group(2'h2, 1'b0, 3'h1);
		// Abort while blanking or while the timer counts.
		for (i = 0; i < 2; i++) begin
			setup(i == 0 ? 2'h0 : 2'h2, 1'b0, 3'h2, 0);
			timer_preload_value = 16'h0000;
			blanking_time_field = 5'h1f;
			// With the clock enable low a start request must not be taken.
			ce = 1'b0;
			pulse_start(1'b1);
			check(auto_start_bit === 1'b0, "start taken with ce low");
			ce = 1'b1;
			pulse_start(1'b1);
			pwm_sync_input = 1'b1;
			step(5);
			pulse_start(1'b0);
			check(auto_start_bit === 1'b0 && conversion_busy_flag === 1'b0 &&
				timer_run_bit === 1'b0, "abort idle");
			step(40);
			pwm_sync_input = 1'b0;
		end
		// Abort in mid-conversion waits for the converter.
		setup(2'h3, 1'b0, 3'h3, 1);
		hold_done = 1'b1;
		pulse_start(1'b1);
		wait_busy();
		pulse_start(1'b1);
		pulse_start(1'b0);
		step(3);
		check(conversion_busy_flag === 1'b1, "busy dropped early");
		discard = 1'b1;
		hold_done = 1'b0;
		wait_cnt(1);
		step(2);
		check(conversion_busy_flag === 1'b0 && converter_irq_flag === 1'b0 &&
			channel_one_sum === 16'h0000, "abort busy");
		discard = 1'b0;
		step(30);
		run_group(2'h3, 1'b0, 3'h1);
		check(exp_q.size() == 0, "starts missing");
		report_and_stop();
	end
endmodule

// file: logic/atseq_pkg.sv
// Shared constants, encodings and state type of the auto-trigger sequencer.
package atseq_pkg;
	localparam int DATA_W_DEF = 12;
	localparam int ACC_GROW = 4;
	localparam int CLK_NS = 100;
	localparam int LEB_STEP_NS = 100;
	localparam int INTERVAL_STEP_NS = 1000;
	localparam int LEB_STEP_CYC_RAW = (LEB_STEP_NS + CLK_NS - 1) / CLK_NS;
	localparam int LEB_STEP_CYC = (LEB_STEP_CYC_RAW < 1) ? 1 : LEB_STEP_CYC_RAW;
	localparam int INTERVAL_STEP_CYC_RAW =
		(INTERVAL_STEP_NS + CLK_NS - 1) / CLK_NS;
	localparam int INTERVAL_STEP_CYC =
		(INTERVAL_STEP_CYC_RAW < 1) ? 1 : INTERVAL_STEP_CYC_RAW;
	localparam int DLY_W = 10;
	localparam int CNT_W = 5;
	localparam int SYNC_N = 2;
	localparam int TMR_W = 16;
	localparam logic [1:0] TRG_PWM = 2'h0;
	localparam logic [1:0] TRG_CMP = 2'h1;
	localparam logic [1:0] TRG_ARM = 2'h2;
	localparam logic [1:0] TRG_NOW = 2'h3;
	localparam logic [2:0] GRP_OFF = 3'h0;
	localparam logic [2:0] GRP_MAX = 3'h5;
	localparam logic [4:0] GRP_MAX_N = 5'h10;
	localparam logic [15:0] TMR_FULL = 16'hffff;
	localparam logic [15:0] TMR_RST = 16'h0000;
	typedef enum logic [6:0] {
		S_IDLE = 7'h01,
		S_WAIT = 7'h02,
		S_BLANK = 7'h04,
		S_TIMER = 7'h08,
		S_CONV1 = 7'h10,
		S_GAP = 7'h20,
		S_CONV2 = 7'h40
	} atseq_state_t;
	localparam atseq_state_t S_RESET = S_IDLE;
endpackage

// file: logic/atseq_timer.sv
// Up-counting 16-bit trigger timer with preload and overflow pulse.
`timescale 1ns/1ps
module atseq_timer (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	atseq_tmr_if.tmr tif
);
	logic [15:0] cnt;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			cnt <= atseq_pkg::TMR_RST;
			tif.run <= 1'b0;
			tif.ovf <= 1'b0;
		end else if (ce) begin
			tif.ovf <= 1'b0;
			if (tif.stop) begin
				tif.run <= 1'b0;
			end else if (tif.start) begin
				cnt <= tif.preload;
				tif.run <= 1'b1;
			end else if (tif.run) begin
				if (cnt == atseq_pkg::TMR_FULL) begin
					tif.run <= 1'b0;
					tif.ovf <= 1'b1;
				end else begin
					cnt <= cnt + 16'h0001;
				end
			end
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst || !ce);

	AST_TMR_OVF: assert property (
		tif.run && cnt == atseq_pkg::TMR_FULL && !tif.stop && !tif.start
		|=> !tif.run && tif.ovf)
		else $error("timer did not stop with overflow at full count");
	AST_TMR_COUNT: assert property (
		tif.run && cnt != atseq_pkg::TMR_FULL && !tif.stop && !tif.start
		|=> tif.run && cnt == $past(cnt) + 16'h0001 && !tif.ovf)
		else $error("timer did not count up by one");
endmodule

// file: logic/atseq_tmr_if.sv
// Handshake between the sequencer control and its 16-bit trigger timer.
`timescale 1ns/1ps
interface atseq_tmr_if;
	logic start;
	logic stop;
	logic [15:0] preload;
	logic ovf;
	logic run;
	modport ctrl (output start, output stop, output preload,
		input ovf, input run);
	modport tmr (input start, input stop, input preload,
		output ovf, output run);
endinterface

// file: logic/atseq_top.sv
// Automatic-trigger sequencer for the successive-approximation converter.
`timescale 1ns/1ps
// Functional notes
// - Auto mode needs nonzero group count.
// - Per-channel source type and 4-bit select.
// - Arm only on start bit rising.
// - Two-channel: ch1, interval, then ch2.
// - Accumulate each result into its channel sum, except one landing during an abort.
// - Immediate mode spaces conversions by interval.
// - Trigger select: PWM, comparator, start, immediate.
// - Timer triggers use 16-bit up counter.
// - PWM edge starts blanking, then conversion.
// - Count field encodes 1, 2, 4, 8, 16.
// - Group done clears start, sets flag.
// - No retrigger until group finishes.
// - Abort while busy waits for conversion end.
// - Abort while idle-converter resets at once.
// - Completed group still raises the interrupt.
// - Arming clears the retrigger-overlap flag.
// - Edge during conversion sets overlap, ignored.
// - Busy flag spans each conversion.
// - Timer runs preload to full, then stops.
module atseq_top #(
	parameter int DATA_W = atseq_pkg::DATA_W_DEF
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic two_channel_enable,
	input wire logic [2:0] group_count_field,
	input wire logic [1:0] trigger_select_field,
	input wire logic [3:0] interval_field,
	input wire logic [4:0] blanking_time_field,
	input wire logic ch1_source_type,
	input wire logic [3:0] ch1_source_select,
	input wire logic ch2_source_type,
	input wire logic [3:0] ch2_source_select,
	input wire logic timer_ext_enable,
	input wire logic [15:0] timer_preload_value,
	input wire logic start_set,
	input wire logic start_clear,
	input wire logic irq_flag_clear,
	input wire logic pwm_sync_input,
	input wire logic comparator_output_signal,
	input wire logic conv_done,
	input wire logic [DATA_W-1:0] conv_data,
	output logic auto_start_bit,
	output logic converter_irq_flag,
	output logic retrigger_overlap_flag,
	output logic conversion_busy_flag,
	output logic conv_start,
	output logic channel_source_type,
	output logic [3:0] channel_source_select,
	output logic [DATA_W+atseq_pkg::ACC_GROW-1:0] channel_one_sum,
	output logic [DATA_W+atseq_pkg::ACC_GROW-1:0] channel_two_sum,
	output logic timer_run_bit
);
	localparam int SUM_W = DATA_W + atseq_pkg::ACC_GROW;
	localparam int DW = atseq_pkg::DLY_W;

	generate
		if (DATA_W < 1 || DATA_W > 16) begin : g_bad_width
			$error("DATA_W must lie between 1 and 16");
		end
	endgenerate

	atseq_pkg::atseq_state_t state;
	atseq_pkg::atseq_state_t next_state;
	atseq_pkg::atseq_state_t follow_state;
	logic [DW-1:0] dly;
	logic [DW-1:0] next_dly;
	logic [DW-1:0] blank_cyc;
	logic [DW-1:0] gap_cyc;
	logic [atseq_pkg::CNT_W-1:0] done_cnt;
	logic [atseq_pkg::CNT_W-1:0] n_target;
	logic aborting;
	logic conv_go;
	logic tmr_go;
	logic arm;
	logic abort_now;
	logic conv_fin;
	logic last;
	logic step_done;
	logic complete;
	logic in_conv;
	logic overlap_ev;
	logic last_pair_done;
	logic [atseq_pkg::SYNC_N-1:0] raw_in;
	logic [atseq_pkg::SYNC_N-1:0] rise;

	atseq_tmr_if tif ();

	atseq_timer u_timer (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.tif(tif)
	);

	// Both trigger sources may come from asynchronous analog logic, so each
	// is filtered: a level is accepted only once two later stages agree.
	assign raw_in = {comparator_output_signal, pwm_sync_input};
	genvar gi;
	generate
		for (gi = 0; gi < atseq_pkg::SYNC_N; gi++) begin : g_sync
			logic [2:0] sh;
			logic level;
			always_ff @(posedge clk) begin
				if (!nrst) begin
					sh <= 3'h0;
					level <= 1'b0;
				end else if (ce) begin
					sh <= {sh[1:0], raw_in[gi]};
					if (sh[1] == sh[2]) begin
						level <= sh[2];
					end
				end
			end
			assign rise[gi] = sh[1] & sh[2] & ~level;
		end
	endgenerate

	always_comb begin
		unique case (group_count_field)
			3'h1: n_target = 5'h01;
			3'h2: n_target = 5'h02;
			3'h3: n_target = 5'h04;
			3'h4: n_target = 5'h08;
			default: n_target = atseq_pkg::GRP_MAX_N;
		endcase
	end

	assign blank_cyc = DW'(blanking_time_field * atseq_pkg::LEB_STEP_CYC);
	assign gap_cyc = DW'(interval_field * atseq_pkg::INTERVAL_STEP_CYC);
	assign arm = start_set && !auto_start_bit
		&& state == atseq_pkg::S_IDLE
		&& group_count_field != atseq_pkg::GRP_OFF;
	assign abort_now = start_clear && state != atseq_pkg::S_IDLE && !aborting;
	assign conv_fin = conv_done && conversion_busy_flag;
	assign last = (done_cnt + 5'h01) == n_target;
	assign step_done = conv_fin && !aborting
		&& (state == atseq_pkg::S_CONV2
		|| (state == atseq_pkg::S_CONV1 && !two_channel_enable));
	assign complete = step_done && last;
	assign in_conv = state == atseq_pkg::S_CONV1
		|| state == atseq_pkg::S_GAP || state == atseq_pkg::S_CONV2;
	assign overlap_ev = in_conv
		&& ((trigger_select_field == atseq_pkg::TRG_PWM && rise[0])
		|| (trigger_select_field == atseq_pkg::TRG_CMP && rise[1]));

	// In immediate mode the gap state also spaces one pair from the next.
	assign follow_state = last ? atseq_pkg::S_IDLE :
		trigger_select_field == atseq_pkg::TRG_ARM ? atseq_pkg::S_TIMER :
		trigger_select_field == atseq_pkg::TRG_NOW ? atseq_pkg::S_GAP :
		atseq_pkg::S_WAIT;

	always_comb begin
		next_state = state;
		next_dly = dly;
		conv_go = 1'b0;
		tmr_go = 1'b0;
		unique case (state)
			atseq_pkg::S_IDLE: begin
				if (arm) begin
					unique case (trigger_select_field)
						atseq_pkg::TRG_PWM,
						atseq_pkg::TRG_CMP: next_state = atseq_pkg::S_WAIT;
						atseq_pkg::TRG_ARM: begin
							tmr_go = 1'b1;
							next_state = atseq_pkg::S_TIMER;
						end
						atseq_pkg::TRG_NOW: begin
							conv_go = 1'b1;
							next_state = atseq_pkg::S_CONV1;
						end
					endcase
				end
			end
			atseq_pkg::S_WAIT: begin
				if (trigger_select_field == atseq_pkg::TRG_PWM && rise[0]) begin
					next_state = atseq_pkg::S_BLANK;
					next_dly = blank_cyc;
				end else if (trigger_select_field == atseq_pkg::TRG_CMP
					&& rise[1] && timer_ext_enable) begin
					tmr_go = 1'b1;
					next_state = atseq_pkg::S_TIMER;
				end
			end
			atseq_pkg::S_BLANK: begin
				if (dly == '0) begin
					conv_go = 1'b1;
					next_state = atseq_pkg::S_CONV1;
				end else begin
					next_dly = dly - 1'b1;
				end
			end
			atseq_pkg::S_TIMER: begin
				if (tif.ovf) begin
					conv_go = 1'b1;
					next_state = atseq_pkg::S_CONV1;
				end
			end
			atseq_pkg::S_CONV1: begin
				if (conv_fin) begin
					if (aborting) begin
						next_state = atseq_pkg::S_IDLE;
					end else if (two_channel_enable) begin
						next_state = atseq_pkg::S_GAP;
						next_dly = gap_cyc;
					end else begin
						next_state = follow_state;
						next_dly = gap_cyc;
						tmr_go = follow_state == atseq_pkg::S_TIMER;
					end
				end
			end
			atseq_pkg::S_GAP: begin
				if (dly == '0) begin
					conv_go = 1'b1;
					next_state = two_channel_enable && !last_pair_done
						? atseq_pkg::S_CONV2 : atseq_pkg::S_CONV1;
				end else begin
					next_dly = dly - 1'b1;
				end
			end
			atseq_pkg::S_CONV2: begin
				if (conv_fin) begin
					if (aborting) begin
						next_state = atseq_pkg::S_IDLE;
					end else begin
						next_state = follow_state;
						next_dly = gap_cyc;
						tmr_go = follow_state == atseq_pkg::S_TIMER;
					end
				end
			end
		endcase
		// An abort taken in the very cycle a result lands finds busy low
		// only afterwards; it is finished here so no new conversion starts.
		if ((abort_now || aborting) && !conversion_busy_flag) begin
			next_state = atseq_pkg::S_IDLE;
			conv_go = 1'b0;
			tmr_go = 1'b0;
		end
	end

	// Marks a gap that spaces whole pairs rather than ch1 from ch2.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			last_pair_done <= 1'b0;
		end else if (ce) begin
			if (step_done) begin
				last_pair_done <= 1'b1;
			end else if (conv_go) begin
				last_pair_done <= 1'b0;
			end
		end
	end

	assign tif.start = tmr_go;
	assign tif.stop = next_state == atseq_pkg::S_IDLE;
	assign tif.preload = timer_preload_value;
	assign timer_run_bit = tif.run;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state <= atseq_pkg::S_RESET;
			dly <= '0;
			done_cnt <= '0;
			aborting <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			dly <= next_dly;
			if (arm) begin
				done_cnt <= '0;
			end else if (step_done) begin
				done_cnt <= done_cnt + 5'h01;
			end
			if (next_state == atseq_pkg::S_IDLE) begin
				aborting <= 1'b0;
			end else if (abort_now) begin
				aborting <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			auto_start_bit <= 1'b0;
			converter_irq_flag <= 1'b0;
			retrigger_overlap_flag <= 1'b0;
		end else if (ce) begin
			if (arm) begin
				auto_start_bit <= 1'b1;
			end else if (complete || start_clear) begin
				auto_start_bit <= 1'b0;
			end
			// A completion in the cycle of a software clear keeps the flag.
			if (complete) begin
				converter_irq_flag <= 1'b1;
			end else if (irq_flag_clear) begin
				converter_irq_flag <= 1'b0;
			end
			if (overlap_ev) begin
				retrigger_overlap_flag <= 1'b1;
			end else if (arm) begin
				retrigger_overlap_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			conversion_busy_flag <= 1'b0;
			conv_start <= 1'b0;
			channel_source_type <= 1'b0;
			channel_source_select <= 4'h0;
		end else if (ce) begin
			conv_start <= conv_go;
			if (conv_go) begin
				conversion_busy_flag <= 1'b1;
			end else if (conv_fin) begin
				conversion_busy_flag <= 1'b0;
			end
			if (conv_go && next_state == atseq_pkg::S_CONV2) begin
				channel_source_type <= ch2_source_type;
				channel_source_select <= ch2_source_select;
			end else if (conv_go) begin
				channel_source_type <= ch1_source_type;
				channel_source_select <= ch1_source_select;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			channel_one_sum <= '0;
			channel_two_sum <= '0;
		end else if (ce) begin
			if (arm) begin
				channel_one_sum <= '0;
				channel_two_sum <= '0;
			end else if (conv_fin && !aborting) begin
				if (state == atseq_pkg::S_CONV1) begin
					channel_one_sum <= channel_one_sum + SUM_W'(conv_data);
				end else if (state == atseq_pkg::S_CONV2) begin
					channel_two_sum <= channel_two_sum + SUM_W'(conv_data);
				end
			end
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst || !ce);

	AST_ARM_CLEARS: assert property (
		arm |=> done_cnt == '0 && channel_one_sum == '0
		&& channel_two_sum == '0 && auto_start_bit)
		else $error("arming did not clear count and sums");
	AST_ARM_NONZERO: assert property (
		$rose(auto_start_bit) |-> $past(group_count_field) != 3'h0)
		else $error("armed with a zero group count");
	AST_OVERLAP_CLEAR: assert property (
		arm |=> !retrigger_overlap_flag)
		else $error("overlap flag not cleared on arming");
	AST_OVERLAP_SET: assert property (
		overlap_ev && !conv_go |=> retrigger_overlap_flag && !conv_start)
		else $error("edge during conversion not flagged");
	AST_DONE: assert property (
		complete |=> !auto_start_bit && converter_irq_flag
		&& state == atseq_pkg::S_IDLE)
		else $error("group completion not signalled");
	AST_BUSY: assert property (
		conv_start |-> conversion_busy_flag)
		else $error("conversion started without busy");
	AST_ABORT_NOW: assert property (
		abort_now && !conversion_busy_flag |=> state == atseq_pkg::S_IDLE
		&& !timer_run_bit)
		else $error("idle abort did not reset at once");
	AST_ABORT_WAIT: assert property (
		abort_now && conversion_busy_flag && !conv_fin
		|=> state != atseq_pkg::S_IDLE)
		else $error("busy abort returned before conversion end");
	AST_CH2_AFTER_GAP: assert property (
		state == atseq_pkg::S_CONV1 && conv_fin && !aborting
		&& two_channel_enable |=> state == atseq_pkg::S_GAP)
		else $error("ch1 was not followed by the interval");
	AST_ACC1: assert property (
		state == atseq_pkg::S_CONV1 && conv_fin && !aborting
		|=> channel_one_sum == $past(channel_one_sum)
		+ SUM_W'($past(conv_data)))
		else $error("ch1 sum not updated");
	COV_GROUP_DONE: cover property (complete);
	COV_OVERLAP: cover property (overlap_ev);
	COV_BUSY_ABORT: cover property (abort_now && conversion_busy_flag);
endmodule
